// ===== hdl/rapu_pkg.sv
// Constants, codes and helper functions of the region protection unit
package rapu_pkg;

  // Region count and field geometry
  localparam int RAPU_NREG = 16;
  localparam int RAPU_NSUB = 8;
  localparam int RAPU_BASE_LSB = 5;
  localparam logic [3:0] RAPU_TOP_IDX = 4'hf;

  // Size code n gives a region of 2^(n+1) bytes
  localparam logic [4:0] RAPU_SIZE_MIN = 5'h04; // 32 bytes
  localparam logic [4:0] RAPU_SIZE_MAX = 5'h1f; // 4 Gbytes
  localparam logic [4:0] RAPU_SUB_MIN = 5'h07;  // 256 bytes, 8 x 32

  // Values after reset
  localparam logic RAPU_RST_EN = 1'b0;
  localparam logic RAPU_RST_XN = 1'b0;
  localparam logic [2:0] RAPU_RST_AP = 3'h0;
  localparam logic [4:0] RAPU_RST_SIZE = 5'h04;
  localparam logic [7:0] RAPU_RST_SRD = 8'h00;
  localparam logic [26:0] RAPU_RST_BASE = 27'h0000000;
  localparam logic [3:0] RAPU_RST_REGION = 4'h0;
  localparam logic [31:0] RAPU_RST_ADDR = 32'h00000000;

  // Access permission codes
  typedef enum logic [2:0] {
    AP_NONE = 3'h0,
    AP_PRIV_RW = 3'h1,
    AP_PRIV_RW_USER_RO = 3'h2,
    AP_FULL = 3'h3,
    AP_PRIV_RO = 3'h5,
    AP_RO = 3'h6
  } rapu_ap_e;

  // Mask of the address bits that a region of this size compares
  function automatic logic [31:0] rapu_size_mask(input logic [4:0] size);
    logic [32:0] span;
    span = 33'h000000001 << ({1'b0, size} + 6'h01);
    return ~(span[31:0] - 32'h00000001) & {32{size != RAPU_SIZE_MAX}};
  endfunction : rapu_size_mask

  // Subregion number: the three address bits just below the region size
  function automatic logic [2:0] rapu_sub_idx(input logic [31:0] addr,
                                              input logic [4:0] size);
    logic [31:0] sh;
    sh = addr >> (size - 5'h02);
    return sh[2:0];
  endfunction : rapu_sub_idx

  // Permission check; reserved codes deny everything
  function automatic logic rapu_ap_ok(input logic [2:0] ap,
                                      input logic priv,
                                      input logic wr);
    logic ok;
    ok = 1'b0;
    case (ap)
      AP_PRIV_RW: ok = priv;
      AP_PRIV_RW_USER_RO: ok = priv | ~wr;
      AP_FULL: ok = 1'b1;
      AP_PRIV_RO: ok = priv & ~wr;
      AP_RO: ok = ~wr;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : rapu_ap_ok

endpackage : rapu_pkg

// ===== hdl/rapu_region_match.sv
// Address match of one protection region, with subregion disables
module rapu_region_match
  import rapu_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic [26:0] base,
  input wire logic [4:0] size,
  input wire logic [7:0] srd,
  input wire logic en,
  output logic hit
);

  logic [31:0] mask;
  logic in_range;
  logic sub_off;

  // Base taken as aligned to the size: low base bits are simply ignored
  always_comb begin
    mask = rapu_size_mask(size);
    in_range = ((addr ^ {base, 5'h00}) & mask) == 32'h00000000;
    // Regions below 256 bytes have no subregions
    sub_off = (size >= RAPU_SUB_MIN) && srd[rapu_sub_idx(addr, size)];
    hit = en && in_range && !sub_off;
  end

endmodule : rapu_region_match

// ===== hdl/rapu_top.sv
// Top level of the region protection unit: table, matchers and decision
module rapu_top
  import rapu_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic CE,
  input wire logic PROT_EN,
  input wire logic PRIV_DEFAULT,
  input wire logic CFG_WE,
  input wire logic [3:0] CFG_IDX,
  input wire logic [31:0] CFG_BASE,
  input wire logic [4:0] CFG_SIZE,
  input wire logic [7:0] CFG_SRD,
  input wire logic [2:0] CFG_AP,
  input wire logic CFG_XN,
  input wire logic CFG_EN,
  input wire logic ACC_VALID,
  input wire logic [31:0] ACC_ADDR,
  input wire logic ACC_WRITE,
  input wire logic ACC_FETCH,
  input wire logic ACC_PRIV,
  output logic RSP_VALID,
  output logic RSP_ALLOW,
  output logic RSP_HIT,
  output logic [3:0] RSP_REGION,
  output logic FAULT,
  output logic [31:0] FAULT_ADDR,
  output logic STAT_ACTIVE
);

  // Region table
  logic [26:0] cfg_base [RAPU_NREG];
  logic [4:0] cfg_size [RAPU_NREG];
  logic [7:0] cfg_srd [RAPU_NREG];
  logic [2:0] cfg_ap [RAPU_NREG];
  logic cfg_xn [RAPU_NREG];
  logic cfg_en [RAPU_NREG];
  logic [26:0] next_cfg_base [RAPU_NREG];
  logic [4:0] next_cfg_size [RAPU_NREG];
  logic [7:0] next_cfg_srd [RAPU_NREG];
  logic [2:0] next_cfg_ap [RAPU_NREG];
  logic next_cfg_xn [RAPU_NREG];
  logic next_cfg_en [RAPU_NREG];

  // Decision path
  logic [RAPU_NREG-1:0] match_vec;
  logic hit_any;
  logic [3:0] hit_idx;
  logic allow;
  logic next_rsp_valid;
  logic next_rsp_allow;
  logic next_rsp_hit;
  logic [3:0] next_rsp_region;
  logic next_fault;
  logic [31:0] next_fault_addr;
  logic next_stat_active;

  // Highest-numbered set bit of the match vector
  function automatic logic [3:0] top_hit(input logic [RAPU_NREG-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < RAPU_NREG; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : top_hit

  // Table write: one region per strobe, others untouched
  always_comb begin
    next_cfg_base = cfg_base;
    next_cfg_size = cfg_size;
    next_cfg_srd = cfg_srd;
    next_cfg_ap = cfg_ap;
    next_cfg_xn = cfg_xn;
    next_cfg_en = cfg_en;
    if (CFG_WE) begin
      next_cfg_base[CFG_IDX] = CFG_BASE[31:RAPU_BASE_LSB];
      // Codes below the minimum would make a region smaller than 32 bytes
      if (CFG_SIZE < RAPU_SIZE_MIN) begin
        next_cfg_size[CFG_IDX] = RAPU_SIZE_MIN;
      end else begin
        next_cfg_size[CFG_IDX] = CFG_SIZE;
      end
      next_cfg_srd[CFG_IDX] = CFG_SRD;
      next_cfg_ap[CFG_IDX] = CFG_AP;
      next_cfg_xn[CFG_IDX] = CFG_XN;
      next_cfg_en[CFG_IDX] = CFG_EN;
    end
  end

  // Table registers, frozen while CE is low
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      for (int i = 0; i < RAPU_NREG; i++) begin
        cfg_base[i] <= RAPU_RST_BASE;
        cfg_size[i] <= RAPU_RST_SIZE;
        cfg_srd[i] <= RAPU_RST_SRD;
        cfg_ap[i] <= RAPU_RST_AP;
        cfg_xn[i] <= RAPU_RST_XN;
        cfg_en[i] <= RAPU_RST_EN;
      end
    end else if (CE) begin
      cfg_base <= next_cfg_base;
      cfg_size <= next_cfg_size;
      cfg_srd <= next_cfg_srd;
      cfg_ap <= next_cfg_ap;
      cfg_xn <= next_cfg_xn;
      cfg_en <= next_cfg_en;
    end
  end

  // One matcher per region, all compared in parallel
  for (genvar g = 0; g < RAPU_NREG; g++) begin : g_reg
    rapu_region_match u_match (
      .addr(ACC_ADDR),
      .base(cfg_base[g]),
      .size(cfg_size[g]),
      .srd(cfg_srd[g]),
      .en(cfg_en[g]),
      .hit(match_vec[g])
    );
  end

  // Permission decision; fetches are checked with ACC_WRITE as driven and also honour execute-never
  always_comb begin
    hit_any = |match_vec;
    hit_idx = top_hit(match_vec);
    if (!PROT_EN) begin
      allow = 1'b1;
    end else if (!hit_any) begin
      // Background map only for privileged code, and only if enabled
      allow = ACC_PRIV && PRIV_DEFAULT;
    end else begin
      allow = rapu_ap_ok(cfg_ap[hit_idx], ACC_PRIV, ACC_WRITE)
              && !(ACC_FETCH && cfg_xn[hit_idx]);
    end
  end

  // Response and fault capture
  always_comb begin
    next_rsp_valid = ACC_VALID;
    next_rsp_allow = ACC_VALID && allow;
    next_rsp_hit = ACC_VALID && PROT_EN && hit_any;
    next_rsp_region = ACC_VALID ? hit_idx : RSP_REGION;
    next_fault = ACC_VALID && !allow;
    next_fault_addr = FAULT_ADDR;
    if (ACC_VALID && !allow) begin
      next_fault_addr = ACC_ADDR;
    end
    next_stat_active = PROT_EN;
  end

  // One-cycle latency keeps the sixteen comparators off the output path
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      RSP_VALID <= 1'b0;
      RSP_ALLOW <= 1'b0;
      RSP_HIT <= 1'b0;
      RSP_REGION <= RAPU_RST_REGION;
      FAULT <= 1'b0;
      FAULT_ADDR <= RAPU_RST_ADDR;
      STAT_ACTIVE <= 1'b0;
    end else if (CE) begin
      RSP_VALID <= next_rsp_valid;
      RSP_ALLOW <= next_rsp_allow;
      RSP_HIT <= next_rsp_hit;
      RSP_REGION <= next_rsp_region;
      FAULT <= next_fault;
      FAULT_ADDR <= next_fault_addr;
      STAT_ACTIVE <= next_stat_active;
    end
  end

  // Helper: previous edge was live (out of reset, CE high)
  logic live;
  logic [2:0] sub0;
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      live <= 1'b0;
    end else begin
      live <= CE;
    end
  end
  assign sub0 = rapu_sub_idx(ACC_ADDR, cfg_size[0]);

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  property p_no_region_fault;
    live && $past(ACC_VALID && PROT_EN && !hit_any && !PRIV_DEFAULT)
      |-> FAULT && RSP_VALID && !RSP_ALLOW;
  endproperty
  a_no_region_fault: assert property (p_no_region_fault)
    else $error("unmatched access not faulted");

  property p_sub_disable;
    (cfg_size[0] >= RAPU_SUB_MIN && cfg_srd[0][sub0]) |-> !match_vec[0];
  endproperty
  a_sub_disable: assert property (p_sub_disable)
    else $error("disabled subregion matched");

  property p_cfg_write;
    live && $past(CFG_WE) |->
      cfg_ap[$past(CFG_IDX)] == $past(CFG_AP) &&
      cfg_srd[$past(CFG_IDX)] == $past(CFG_SRD) &&
      cfg_base[$past(CFG_IDX)] == $past(CFG_BASE[31:RAPU_BASE_LSB]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("region write not stored");

  property p_size_full;
    (cfg_en[0] && cfg_size[0] == RAPU_SIZE_MAX && cfg_srd[0] == 8'h00)
      |-> match_vec[0];
  endproperty
  a_size_full: assert property (p_size_full)
    else $error("4 Gbyte region missed an address");

  property p_size_min;
    (cfg_size[0] == RAPU_SIZE_MIN && ACC_ADDR[31:5] != cfg_base[0])
      |-> !match_vec[0];
  endproperty
  a_size_min: assert property (p_size_min)
    else $error("32 byte region matched outside itself");

  property p_user_priv_only;
    live && $past(ACC_VALID && PROT_EN && hit_any && !ACC_PRIV &&
                  cfg_ap[hit_idx] == AP_PRIV_RW) |-> FAULT;
  endproperty
  a_user_priv_only: assert property (p_user_priv_only)
    else $error("user access to privileged region allowed");

  property p_priv_rw;
    live && $past(ACC_VALID && PROT_EN && hit_any && ACC_PRIV &&
                  !ACC_FETCH && cfg_ap[hit_idx] == AP_PRIV_RW)
      |-> RSP_ALLOW && !FAULT;
  endproperty
  a_priv_rw: assert property (p_priv_rw)
    else $error("privileged access wrongly blocked");

  property p_fault_capture;
    live && $past(ACC_VALID && !allow)
      |-> FAULT && !RSP_ALLOW && FAULT_ADDR == $past(ACC_ADDR);
  endproperty
  a_fault_capture: assert property (p_fault_capture)
    else $error("violation not blocked or address lost");

  property p_read_deny;
    live && $past(ACC_VALID && PROT_EN && hit_any && !ACC_WRITE &&
                  cfg_ap[hit_idx] == AP_NONE) |-> FAULT;
  endproperty
  a_read_deny: assert property (p_read_deny)
    else $error("read of no-access region allowed");

  property p_top_wins;
    live && $past(ACC_VALID && PROT_EN && match_vec[RAPU_NREG-1])
      |-> RSP_HIT && RSP_REGION == RAPU_TOP_IDX;
  endproperty
  a_top_wins: assert property (p_top_wins)
    else $error("highest region did not win");

  property p_aligned;
    match_vec[0] |->
      ((ACC_ADDR ^ {cfg_base[0], 5'h00}) & rapu_size_mask(cfg_size[0]))
        == 32'h00000000;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("match outside aligned region");

  property p_c_fault;
    RSP_VALID && FAULT;
  endproperty
  c_fault: cover property (p_c_fault);

  property p_c_overlap;
    ACC_VALID && PROT_EN && $countones(match_vec) > 1;
  endproperty
  c_overlap: cover property (p_c_overlap);

  property p_c_user_ok;
    ACC_VALID && PROT_EN && hit_any && !ACC_PRIV && allow;
  endproperty
  c_user_ok: cover property (p_c_user_ok);

endmodule : rapu_top

// ===== testbench/rapu_core_model.sv
// Core fetch and load/store path model driving one access per call
module rapu_core_model (
  input wire logic clk,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_write,
  output logic acc_fetch,
  output logic acc_priv
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at start
  initial begin
    acc_valid = 1'h0;
    acc_addr = 32'h0;
    acc_write = 1'h0;
    acc_fetch = 1'h0;
    acc_priv = 1'h0;
  end

  // Request stands for one edge; no back-pressure to wait on
  task automatic issue(input logic [31:0] a, input logic w, f, p);
    @(posedge clk);
    #1;
    acc_valid = 1'h1;
    acc_addr = a;
    acc_write = w & ~f; // Fetch is a read
    acc_fetch = f;
    acc_priv = p;
    @(posedge clk);
    #1;
    // Released lines show junk, never the old access
    acc_valid = 1'h0;
    acc_addr = ~a;
    acc_write = ~w;
    acc_fetch = ~f;
    acc_priv = ~p;
  endtask : issue
endmodule : rapu_core_model

// ===== testbench/tb_region_access_protection_unit.sv
// Self-checking bench of the region protection unit
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_region_access_protection_unit
  import rapu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS, NRST, CE, PROT_EN, PRIV_DEFAULT, CFG_WE, CFG_XN, CFG_EN;
  logic [3:0] CFG_IDX, RSP_REGION;
  logic [31:0] CFG_BASE, ACC_ADDR, FAULT_ADDR, a;
  logic [4:0] CFG_SIZE;
  logic [7:0] CFG_SRD;
  logic [2:0] CFG_AP;
  logic ACC_VALID, ACC_WRITE, ACC_FETCH, ACC_PRIV;
  logic RSP_VALID, RSP_ALLOW, RSP_HIT, FAULT, STAT_ACTIVE;
  logic [63:0] m;
  int fail_count, num_checks, j;
  logic [31:0] tb_base [16];
  logic [4:0] tb_size [16];
  logic [7:0] tb_srd [16];
  logic [2:0] tb_ap [16];
  logic [15:0] tb_xn, tb_en;
  logic [31:0] dir_a [5] = '{32'h20000120, 32'h20000140, 32'h2000021f,
    32'h20000220, 32'h20000200};

  rapu_top u_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE),
    .PROT_EN(PROT_EN), .PRIV_DEFAULT(PRIV_DEFAULT), .CFG_WE(CFG_WE),
    .CFG_IDX(CFG_IDX), .CFG_BASE(CFG_BASE), .CFG_SIZE(CFG_SIZE),
    .CFG_SRD(CFG_SRD), .CFG_AP(CFG_AP), .CFG_XN(CFG_XN), .CFG_EN(CFG_EN),
    .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR), .ACC_WRITE(ACC_WRITE),
    .ACC_FETCH(ACC_FETCH), .ACC_PRIV(ACC_PRIV), .RSP_VALID(RSP_VALID),
    .RSP_ALLOW(RSP_ALLOW), .RSP_HIT(RSP_HIT), .RSP_REGION(RSP_REGION),
    .FAULT(FAULT), .FAULT_ADDR(FAULT_ADDR), .STAT_ACTIVE(STAT_ACTIVE));
  rapu_core_model u_core (.clk(CLK_SYS), .acc_valid(ACC_VALID),
    .acc_addr(ACC_ADDR), .acc_write(ACC_WRITE), .acc_fetch(ACC_FETCH),
    .acc_priv(ACC_PRIV));

  // 100 MHz clock
  initial begin
    CLK_SYS = 1'h0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  function automatic logic rb();
    return 1'($urandom);
  endfunction : rb

  // Reference decision: {hit, allow, region}; highest match wins
  function automatic logic [5:0] expect_rsp(input logic [31:0] ad,
                                            input logic w, f, p);
    logic h, ok;
    logic [3:0] r;
    logic [63:0] mk;
    logic [31:0] s;
    h = 1'h0;
    r = 4'h0;
    ok = 1'h0;
    for (int i = 0; i < 16; i++) begin
      mk = ~((64'h2 << tb_size[i]) - 64'h1);
      s = ad >> (tb_size[i] - 5'h02);
      if (tb_en[i] && ((ad ^ tb_base[i]) & mk[31:0]) == 32'h0 &&
          !(tb_size[i] >= 5'h07 && tb_srd[i][s[2:0]])) begin
        h = 1'h1;
        r = 4'(i);
      end
    end
    case (tb_ap[r])
      3'h1: ok = p;
      3'h2: ok = p | ~w;
      3'h3: ok = 1'h1;
      3'h5: ok = p & ~w;
      3'h6: ok = ~w;
      default: ok = 1'h0;
    endcase
    if (!h) ok = p & PRIV_DEFAULT;
    if (h && f && tb_xn[r]) ok = 1'h0;
    if (!PROT_EN) begin
      h = 1'h0;
      ok = 1'h1;
    end
    return {h, ok, r};
  endfunction : expect_rsp

  // Region write; the bench table follows only when the write is taken
  task automatic cfg(input logic [3:0] i, input logic [31:0] b,
                     input logic [4:0] sz, input logic [7:0] sd,
                     input logic [2:0] ap, input logic x, en);
    @(posedge CLK_SYS);
    #1;
    CFG_WE = 1'h1;
    CFG_IDX = i;
    CFG_BASE = b;
    CFG_SIZE = sz;
    CFG_SRD = sd;
    CFG_AP = ap;
    CFG_XN = x;
    CFG_EN = en;
    @(posedge CLK_SYS);
    #1;
    CFG_WE = 1'h0;
    if (CE) begin
      tb_base[i] = b;
      tb_size[i] = (sz < 5'h04) ? 5'h04 : sz;
      tb_srd[i] = sd;
      tb_ap[i] = ap;
      tb_xn[i] = x;
      tb_en[i] = en;
    end
  endtask : cfg

  // One access and its one-cycle answer
  task automatic access(input logic [31:0] ad, input logic w, f, p);
    logic [5:0] e;
    e = expect_rsp(ad, w & ~f, f, p);
    u_core.issue(ad, w, f, p);
    `CHK("valid", 1'h1, RSP_VALID)
    `CHK("allow", e[4], RSP_ALLOW)
    `CHK("fault", ~e[4], FAULT)
    `CHK("hit", e[5], RSP_HIT)
    `CHK("active", PROT_EN, STAT_ACTIVE)
    if (PROT_EN) `CHK("region", e[3:0], RSP_REGION)
    if (!e[4]) `CHK("fault_addr", ad, FAULT_ADDR)
  endtask : access

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Hang guard
  initial begin
    repeat (50000) @(posedge CLK_SYS);
    fail_count++;
    summarize();
  end

  initial begin
    j = $urandom(56346);
    {NRST, CE, PROT_EN, PRIV_DEFAULT, CFG_WE, CFG_XN, CFG_EN} = 7'h20;
    {CFG_IDX, CFG_BASE, CFG_SIZE, CFG_SRD, CFG_AP} = '0;
    for (int i = 0; i < 16; i++) begin
      {tb_base[i], tb_srd[i], tb_ap[i]} = '0;
      tb_size[i] = 5'h04;
    end
    {tb_xn, tb_en} = '0;
    repeat (3) @(posedge CLK_SYS);
    #1;
    NRST = 1'h1;
    `CHK("rst_fault_addr", 32'h0, FAULT_ADDR)
    // Empty table: only the privileged background is allowed
    PROT_EN = 1'h1;
    PRIV_DEFAULT = 1'h1;
    for (int c = 0; c < 4; c++) access($urandom, c[0], 1'h0, c[1]);
    // Regions are programmed with checking off, then checking is enabled
    PROT_EN = 1'h0;
    cfg(4'h0, 32'h0, 5'h1f, 8'h00, 3'h3, 1'h0, 1'h1);
    cfg(4'h3, 32'h20000100, 5'h07, 8'h04, 3'h0, 1'h0, 1'h1);
    cfg(4'h5, 32'h2000021f, 5'h04, 8'h00, 3'h1, 1'h0, 1'h1);
    PROT_EN = 1'h1;
    // Overlap, subregion hole and smallest region at every mode
    foreach (dir_a[k]) begin
      for (int c = 0; c < 8; c++) access(dir_a[k], c[0], c[1], c[2]);
    end
    // Every permission code against every access kind
    for (int c = 0; c < 64; c++) begin
      if (c[2:0] == 0) begin
        PROT_EN = 1'h0;
        cfg(4'hf, 32'h40000000, 5'h09, 8'h00, c[5:3], 1'h1, 1'h1);
        PROT_EN = 1'h1;
      end
      access(32'h40000010, c[0], c[1], c[2]);
    end
    // Write with the clock enable low is ignored
    CE = 1'h0;
    cfg(4'hf, 32'h40000000, 5'h09, 8'h00, 3'h3, 1'h0, 1'h1);
    CE = 1'h1;
    access(32'h40000010, 1'h1, 1'h0, 1'h1);
    // Disabled unit checks nothing
    PROT_EN = 1'h0;
    repeat (10) access($urandom, rb(), rb(), rb());
    PROT_EN = 1'h1;
    repeat (4) begin
      PRIV_DEFAULT = rb();
      PROT_EN = 1'h0;
      for (int i = 0; i < 16; i++) cfg(4'(i), $urandom,
        ($urandom_range(0, 7) == 0) ? 5'h1f : 5'($urandom_range(0, 14)),
        8'($urandom), 3'($urandom), rb(), rb());
      PROT_EN = 1'h1;
      repeat (60) begin
        j = $urandom_range(0, 15);
        m = (64'h2 << tb_size[j]) - 64'h1;
        a = (tb_base[j] & ~m[31:0]) | ($urandom & m[31:0]);
        access(a, rb(), rb(), rb());
      end
    end
    summarize();
  end
endmodule : tb_region_access_protection_unit
